/* hdl/chsel_pkg.sv */
// Purpose: constants and carriers for the charger status and event latch group
// Assumes: 8-bit registers at the printed byte offsets
// Notes: reserved bits of the event latches are forced low through the valid-bit masks
package chsel_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_TEMP_STATUS = 8'h0D;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h0E;
    localparam logic [7:0] ADDR_EVENT_FIRST = 8'h0F;
    localparam logic [7:0] ADDR_EVENT_SECOND = 8'h10;

    // ==========================================================
    // implemented bits of each register, everything else reads zero
    localparam logic [7:0] VALID_TEMP = 8'h07;
    localparam logic [7:0] VALID_FAULT = 8'hF0;
    localparam logic [7:0] VALID_EVENT_FIRST = 8'h79;
    localparam logic [7:0] VALID_EVENT_SECOND = 8'h97;
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // field positions
    localparam int FAULT_OVP_BIT = 7;
    localparam int FAULT_TSHUT_BIT = 6;
    localparam int FAULT_BATTERY_OVERVOLTAGE_BIT = 5;
    localparam int FAULT_TIMER_BIT = 4;
    localparam int EV1_ICL_BIT = 6;
    localparam int EV1_IVL_BIT = 5;
    localparam int EV1_THERM_BIT = 4;
    localparam int EV1_WDOG_BIT = 3;
    localparam int EV1_PHASE_BIT = 0;
    localparam int EV2_PGOOD_BIT = 7;
    localparam int EV2_SOURCE_BIT = 4;
    localparam int EV2_TZONE_BIT = 2;
    localparam int EV2_OPTIM_BIT = 1;
    localparam int EV2_SYSMIN_BIT = 0;

    // ==========================================================
    // field encodings
    localparam logic [2:0] TZONE_NORMAL = 3'h0;
    localparam logic [2:0] TZONE_WARM = 3'h2;
    localparam logic [2:0] TZONE_COOL = 3'h3;
    localparam logic [2:0] TZONE_COLD = 3'h5;
    localparam logic [2:0] TZONE_HOT = 3'h6;
    localparam logic [2:0] PHASE_NOT_CHARGING = 3'h0;
    localparam logic [2:0] PHASE_TRICKLE = 3'h1;
    localparam logic [2:0] PHASE_PRECHARGE = 3'h2;
    localparam logic [2:0] PHASE_FAST_CC = 3'h3;
    localparam logic [2:0] PHASE_TAPER_CV = 3'h4;
    localparam logic [2:0] PHASE_TOPOFF = 3'h5;
    localparam logic [2:0] PHASE_DONE = 3'h6;
    localparam logic [2:0] PHASE_RESERVED = 3'h7;
    localparam logic [1:0] OPTIM_DISABLED = 2'h0;
    localparam logic [1:0] OPTIM_RUNNING = 2'h1;
    localparam logic [1:0] OPTIM_MAX_FOUND = 2'h2;
    localparam logic [1:0] OPTIM_RESERVED = 2'h3;

    // ==========================================================
    // internal status signals watched by the block
    typedef struct packed {
        logic [2:0] battery_temp_zone;
        logic input_overvoltage_active;
        logic die_overtemp_shutdown_active;
        logic battery_overvoltage_active;
        logic safety_timer_expired;
        logic input_current_limit_regulation;
        logic input_voltage_limit_regulation;
        logic die_thermal_regulation;
        logic watchdog_expired_state;
        logic [2:0] charge_phase;
        logic power_good_indication;
        logic [2:0] input_source_type;
        logic [1:0] input_optimizer_state;
        logic minimum_system_voltage;
    } chsel_status_s;

endpackage

/* hdl/chsel_status_latches.sv */
// Purpose: read-only status registers and clear-on-read event latches of a charger
// Assumes: status inputs synchronous to clk; one read request per cycle at most
// Notes: read data appears one cycle after the request
`timescale 1ns/1ps

module chsel_status_latches (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // internal status and control
    input wire chsel_pkg::chsel_status_s status_in,
    input wire logic reg_rst,
    input wire logic [7:0] irq_mask_first,
    input wire logic [7:0] irq_mask_second,
    // register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_r,
    output logic rd_valid_r,
    // interrupt
    output logic irq_pulse_r
);

    chsel_pkg::chsel_status_s status_prev_r;
    logic primed_r;
    logic [7:0] latch_first_r;
    logic [7:0] latch_second_r;
    logic [7:0] latch_first_nxt;
    logic [7:0] latch_second_nxt;
    logic [7:0] event_first;
    logic [7:0] event_second;
    logic [7:0] rd_data_nxt;
    logic [7:0] unmasked;
    logic read_first;
    logic read_second;

    // ==========================================================
    // edge and change detection
    // the previous snapshot is only trusted once primed, so reset does not fake events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_prev_r <= '0;
            primed_r <= 1'b0;
        end else begin
            status_prev_r <= status_in;
            primed_r <= 1'b1;
        end
    end

    always_comb begin
        event_first = chsel_pkg::EVENT_RESET;
        event_second = chsel_pkg::EVENT_RESET;
        event_first[chsel_pkg::EV1_ICL_BIT] = status_in.input_current_limit_regulation
            & ~status_prev_r.input_current_limit_regulation;
        event_first[chsel_pkg::EV1_IVL_BIT] = status_in.input_voltage_limit_regulation
            & ~status_prev_r.input_voltage_limit_regulation;
        event_first[chsel_pkg::EV1_THERM_BIT] = status_in.die_thermal_regulation
            & ~status_prev_r.die_thermal_regulation;
        event_first[chsel_pkg::EV1_WDOG_BIT] = status_in.watchdog_expired_state
            & ~status_prev_r.watchdog_expired_state;
        // any charge phase change, every code counts
        event_first[chsel_pkg::EV1_PHASE_BIT] =
            (status_in.charge_phase != status_prev_r.charge_phase);
        event_second[chsel_pkg::EV2_PGOOD_BIT] = status_in.power_good_indication
            ^ status_prev_r.power_good_indication;
        event_second[chsel_pkg::EV2_SOURCE_BIT] =
            (status_in.input_source_type != status_prev_r.input_source_type);
        event_second[chsel_pkg::EV2_TZONE_BIT] =
            (status_in.battery_temp_zone != status_prev_r.battery_temp_zone);
        event_second[chsel_pkg::EV2_OPTIM_BIT] =
            (status_in.input_optimizer_state != status_prev_r.input_optimizer_state);
        event_second[chsel_pkg::EV2_SYSMIN_BIT] = status_in.minimum_system_voltage
            ^ status_prev_r.minimum_system_voltage;
        if (!primed_r) begin
            event_first = chsel_pkg::EVENT_RESET;
            event_second = chsel_pkg::EVENT_RESET;
        end
    end

    // ==========================================================
    // event latches
    assign read_first = rd_en && (rd_addr == chsel_pkg::ADDR_EVENT_FIRST);
    assign read_second = rd_en && (rd_addr == chsel_pkg::ADDR_EVENT_SECOND);

    // read clears, a same-cycle event still sets
    always_comb begin
        latch_first_nxt = ((read_first ? chsel_pkg::EVENT_RESET : latch_first_r) | event_first)
            & chsel_pkg::VALID_EVENT_FIRST;
        latch_second_nxt = ((read_second ? chsel_pkg::EVENT_RESET : latch_second_r)
            | event_second) & chsel_pkg::VALID_EVENT_SECOND;
    end

    // register reset clears, watchdog has no path here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_first_r <= chsel_pkg::EVENT_RESET;
            latch_second_r <= chsel_pkg::EVENT_RESET;
        end else if (reg_rst) begin
            latch_first_r <= chsel_pkg::EVENT_RESET;
            latch_second_r <= chsel_pkg::EVENT_RESET;
        end else begin
            latch_first_r <= latch_first_nxt;
            latch_second_r <= latch_second_nxt;
        end
    end

    // ==========================================================
    // read port
    always_comb begin
        rd_data_nxt = chsel_pkg::READ_ZERO;
        case (rd_addr)
            chsel_pkg::ADDR_TEMP_STATUS: begin
                rd_data_nxt[2:0] = status_in.battery_temp_zone;
            end
            chsel_pkg::ADDR_FAULT_STATUS: begin
                rd_data_nxt[chsel_pkg::FAULT_OVP_BIT] = status_in.input_overvoltage_active;
                rd_data_nxt[chsel_pkg::FAULT_TSHUT_BIT] = status_in.die_overtemp_shutdown_active;
                rd_data_nxt[chsel_pkg::FAULT_BATTERY_OVERVOLTAGE_BIT] = status_in.battery_overvoltage_active;
                rd_data_nxt[chsel_pkg::FAULT_TIMER_BIT] = status_in.safety_timer_expired;
            end
            chsel_pkg::ADDR_EVENT_FIRST: begin
                rd_data_nxt = latch_first_r;
            end
            chsel_pkg::ADDR_EVENT_SECOND: begin
                rd_data_nxt = latch_second_r;
            end
            default: begin
                rd_data_nxt = chsel_pkg::READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= chsel_pkg::READ_ZERO;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r <= rd_en ? rd_data_nxt : chsel_pkg::READ_ZERO;
            rd_valid_r <= rd_en;
        end
    end

    // ==========================================================
    // interrupt pulse
    // pulses on the raw event, so a masked bit still latches but stays silent
    assign unmasked = (event_first & ~irq_mask_first & chsel_pkg::VALID_EVENT_FIRST)
        | (event_second & ~irq_mask_second & chsel_pkg::VALID_EVENT_SECOND);

    // mask zero lets the pulse out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pulse_r <= 1'b0;
        end else begin
            irq_pulse_r <= |unmasked;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence read_first_s;
        rd_en && rd_addr == chsel_pkg::ADDR_EVENT_FIRST && !reg_rst;
    endsequence

    sequence icl_rise_s;
        primed_r && status_in.input_current_limit_regulation
            && !status_prev_r.input_current_limit_regulation && !reg_rst;
    endsequence

    sequence pg_toggle_s;
        primed_r && (status_in.power_good_indication != status_prev_r.power_good_indication)
            && !reg_rst;
    endsequence

    icl_rise_latch_a: assert property (icl_rise_s |=> latch_first_r[6])
        else $error("current-limit rise not latched");
    pg_toggle_latch_a: assert property (pg_toggle_s |=> latch_second_r[7])
        else $error("power-good toggle not latched");
    read_clear_a: assert property ((read_first_s ##0 (event_first == 8'h00))
        |=> latch_first_r == 8'h00)
        else $error("first latch not cleared by read");
    latch_hold_a: assert property ((latch_second_r[2] && !read_second && !reg_rst)
        |=> latch_second_r[2])
        else $error("zone event lost without read");
    reserved_zero_a: assert property (((latch_first_r & 8'h86) == 8'h00)
        && ((latch_second_r & 8'h68) == 8'h00))
        else $error("reserved latch bit set");
    reg_reset_a: assert property (reg_rst |=> (latch_first_r == 8'h00)
        && (latch_second_r == 8'h00))
        else $error("register reset left latches set");
    fault_read_a: assert property ((rd_en && rd_addr == 8'h0E) |=> rd_valid_r
        && rd_data_r == {$past(status_in.input_overvoltage_active),
        $past(status_in.die_overtemp_shutdown_active),
        $past(status_in.battery_overvoltage_active),
        $past(status_in.safety_timer_expired), 4'h0})
        else $error("fault status read wrong");
    temp_read_a: assert property ((rd_en && rd_addr == 8'h0D)
        |=> rd_data_r == {5'h00, $past(status_in.battery_temp_zone)})
        else $error("temperature zone read wrong");
    irq_masked_a: assert property ((irq_mask_first == 8'hFF && irq_mask_second == 8'hFF)
        |=> !irq_pulse_r)
        else $error("masked event raised interrupt");
    irq_phase_a: assert property ((primed_r && !irq_mask_first[0] && !reg_rst
        && status_in.charge_phase != status_prev_r.charge_phase)
        |=> irq_pulse_r && latch_first_r[0])
        else $error("phase change missed");

endmodule // chsel_status_latches

/* verif/chsel_host_model.sv */
// Purpose: host side of the register read port
// Assumes: one read at a time, answer one cycle after the request
// Notes: address is scrambled when idle so stale values never match
`timescale 1ns/1ps

module chsel_host_model (
    // clock
    input wire logic clk,
    // read port
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data_r,
    input wire logic rd_valid_r
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end

    // ==========================================
    // single read
    // host reads acknowledge
    task automatic do_read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge clk);
        #1;
        d = rd_data_r;
        v = rd_valid_r;
        rd_en = 1'b0;
        rd_addr = ~a;
    endtask
endmodule // chsel_host_model

/* verif/chsel_status_latches_bench.sv */
// Purpose: self-checking bench for the status registers and event latches
// Assumes: status carrier edited just after a clock edge
// Notes: every event raised through ev is read twice, the second read must find it cleared
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", w, e, g); end end

module chsel_status_latches_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_rst = 1'b0;
    logic [7:0] m1 = 8'h00;
    logic [7:0] m2 = 8'h00;
    chsel_pkg::chsel_status_s st = '0;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic irq_pulse_r;
    logic [7:0] d;
    logic v;
    int failures = 0;
    int n_checks = 0;

    always #10 clk = ~clk;

    chsel_status_latches i_dut (.clk(clk), .rst_n(rst_n), .status_in(st), .reg_rst(reg_rst),
        .irq_mask_first(m1), .irq_mask_second(m2), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .irq_pulse_r(irq_pulse_r));
    chsel_host_model i_host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));

    // ==========================================
    // shared helpers
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.do_read(a, d, v);
        `CHK("valid", 1'b1, v)
        `CHK("data", e, d)
    endtask

    task automatic ev(input logic [7:0] a, input logic [7:0] e, input logic irq);
        step();
        `CHK("irq", irq, irq_pulse_r)
        rd(a, e);
        rd(a, 8'h00);
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rd(chsel_pkg::ADDR_EVENT_FIRST, 8'h00);
        rd(chsel_pkg::ADDR_EVENT_SECOND, 8'h00);
        rd(8'h20, 8'h00);
        rd(chsel_pkg::ADDR_FAULT_STATUS, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_zone();
        logic [2:0] z [5];
        z = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h0};
        for (int k = 0; k < 5; k++) begin
            st.battery_temp_zone = z[k];
            ev(chsel_pkg::ADDR_EVENT_SECOND, 8'h04, 1'b1);
            rd(chsel_pkg::ADDR_TEMP_STATUS, {5'h00, z[k]});
        end
        $display("test zone done");
    endtask

    task automatic t_fault();
        logic [3:0] f;
        for (int k = 0; k < 5; k++) begin
            f = 4'h8 >> k;
            {st.input_overvoltage_active, st.die_overtemp_shutdown_active,
                st.battery_overvoltage_active, st.safety_timer_expired} = f;
            step();
            rd(chsel_pkg::ADDR_FAULT_STATUS, {f, 4'h0});
        end
        $display("test fault done");
    endtask

    task automatic t_first();
        for (int k = 0; k < 4; k++) begin
            {st.input_current_limit_regulation, st.input_voltage_limit_regulation,
                st.die_thermal_regulation, st.watchdog_expired_state} = 4'h8 >> k;
            ev(chsel_pkg::ADDR_EVENT_FIRST, 8'h40 >> k, 1'b1);
            {st.input_current_limit_regulation, st.input_voltage_limit_regulation,
                st.die_thermal_regulation, st.watchdog_expired_state} = 4'h0;
            ev(chsel_pkg::ADDR_EVENT_FIRST, 8'h00, 1'b0);
        end
        for (int p = 1; p < 9; p++) begin
            st.charge_phase = 3'(p);
            ev(chsel_pkg::ADDR_EVENT_FIRST, 8'h01, 1'b1);
        end
        $display("test first latch done");
    endtask

    task automatic t_second();
        for (int k = 0; k < 2; k++) begin
            st.power_good_indication = ~st.power_good_indication;
            ev(chsel_pkg::ADDR_EVENT_SECOND, 8'h80, 1'b1);
            st.minimum_system_voltage = ~st.minimum_system_voltage;
            ev(chsel_pkg::ADDR_EVENT_SECOND, 8'h01, 1'b1);
            st.input_source_type = st.input_source_type ^ 3'h5;
            ev(chsel_pkg::ADDR_EVENT_SECOND, 8'h10, 1'b1);
        end
        for (int o = 1; o < 5; o++) begin
            st.input_optimizer_state = 2'(o);
            ev(chsel_pkg::ADDR_EVENT_SECOND, 8'h02, 1'b1);
        end
        $display("test second latch done");
    endtask

    task automatic t_mask_rst();
        m1 = 8'h40;
        st.input_current_limit_regulation = 1'b1;
        ev(chsel_pkg::ADDR_EVENT_FIRST, 8'h40, 1'b0);
        st.input_current_limit_regulation = 1'b0;
        m1 = 8'hFF;
        m2 = 8'hFF;
        st.power_good_indication = ~st.power_good_indication;
        ev(chsel_pkg::ADDR_EVENT_SECOND, 8'h80, 1'b0);
        m1 = 8'h00;
        m2 = 8'h00;
        st.power_good_indication = ~st.power_good_indication;
        st.watchdog_expired_state = 1'b1;
        ev(chsel_pkg::ADDR_EVENT_FIRST, 8'h08, 1'b1);
        rd(chsel_pkg::ADDR_EVENT_SECOND, 8'h80);
        st.power_good_indication = ~st.power_good_indication;
        st.charge_phase = chsel_pkg::PHASE_FAST_CC;
        step();
        step();
        reg_rst = 1'b1;
        step();
        step();
        reg_rst = 1'b0;
        rd(chsel_pkg::ADDR_EVENT_FIRST, 8'h00);
        rd(chsel_pkg::ADDR_EVENT_SECOND, 8'h00);
        $display("test mask and reset done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step();
        t_reset();
        t_zone();
        t_fault();
        t_first();
        t_second();
        t_mask_rst();
        test_done();
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        failures++;
        test_done();
    end
endmodule // chsel_status_latches_bench
